// ### design/fsr_pkg.sv
// package of offsets, fields, reset values and timing counts for the flash status block
package fsr_pkg;
    // register byte addresses on the bus
    localparam logic [7:0] ADDR_STATUS_LOCK = 8'h00;
    localparam logic [7:0] ADDR_MARGINAL = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_OP_CTRL = 8'h10;
    // key byte values
    localparam logic [7:0] KEY_READ = 8'h96;
    localparam logic [7:0] KEY_WRITE = 8'hA5;
    // status/lock register bit positions
    localparam int BIT_FAIL = 7;
    localparam int BIT_SEGMENT_A_LOCK = 6;
    localparam int BIT_EMERGENCY_EXIT = 5;
    localparam int BIT_LOCK = 4;
    localparam int BIT_WAIT = 3;
    localparam int BIT_ACCV = 2;
    localparam int BIT_KEY_VIOLATION_FLAG = 1;
    localparam int BIT_BUSY = 0;
    // marginal register bit positions
    localparam int BIT_MARGINAL_ONE_READ_ENABLE = 5;
    localparam int BIT_MARGINAL_ZERO_READ_ENABLE = 4;
    // interrupt status bit positions
    localparam int IRQ_KEY_VIOLATION_FLAG = 0;
    localparam int IRQ_FAIL = 1;
    localparam int IRQ_ACCV = 2;
    localparam int IRQ_DONE = 3;
    localparam int IRQ_W = 4;
    // operation control bit positions
    localparam int OP_ERASE = 0;
    localparam int OP_MASS = 1;
    localparam int OP_WRITE = 2;
    localparam int OP_BLOCK = 3;
    localparam int OP_INFO = 4;
    localparam int OP_START = 5;
    // reset values
    localparam logic RST_LOCK = 1'b1;
    localparam logic RST_SEGMENT_A_LOCK = 1'b1;
    // timing: clock rate and operation durations
    localparam int CLK_HZ = 20000000;
    localparam int WRITE_TIME_NS = 3000;
    localparam int ERASE_TIME_NS = 1000000;
    localparam int WRITE_CYCLES = (WRITE_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int ERASE_CYCLES = (ERASE_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int TIMER_W = 16;
    // sequencer states
    typedef enum logic [1:0] {
        FSR_IDLE = 2'b00,
        FSR_RUN = 2'b01,
        FSR_DONE = 2'b11
    } fsr_state_e;
endpackage

// ### design/fsr_timing_gen.sv
// flash timing generator: counts one write or erase operation
`timescale 1ns/1ps
module fsr_timing_gen #(
    parameter int CW = fsr_pkg::TIMER_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic [CW-1:0] cycles,
    input wire logic abort,
    output logic busy,
    output logic done
);
    fsr_pkg::fsr_state_e state_q;
    logic [CW-1:0] count_q;

    // sequence of idle, run and done; abort drops straight to idle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= fsr_pkg::FSR_IDLE;
            count_q <= '0;
        end else if (abort) begin
            state_q <= fsr_pkg::FSR_IDLE;
            count_q <= '0;
        end else begin
            case (state_q)
                fsr_pkg::FSR_IDLE: begin
                    if (start) begin
                        state_q <= fsr_pkg::FSR_RUN;
                        count_q <= cycles;
                    end
                end
                fsr_pkg::FSR_RUN: begin
                    if (count_q <= CW'(1)) begin
                        state_q <= fsr_pkg::FSR_DONE;
                    end
                    count_q <= count_q - CW'(1);
                end
                fsr_pkg::FSR_DONE: begin
                    state_q <= fsr_pkg::FSR_IDLE;
                end
                default: begin
                    state_q <= fsr_pkg::FSR_IDLE;
                end
            endcase
        end
    end

    assign busy = (state_q == fsr_pkg::FSR_RUN);
    assign done = (state_q == fsr_pkg::FSR_DONE);
endmodule

// ### design/fsr_top.sv
// flash status, lock and marginal read registers with AXI4-Lite access
`timescale 1ns/1ps
module fsr_top #(
    parameter int WRITE_CYC = fsr_pkg::WRITE_CYCLES,
    parameter int ERASE_CYC = fsr_pkg::ERASE_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic por_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cpu_fetch_from_flash,
    input wire logic irq_during_op,
    output logic power_up_clear_reset,
    output logic marginal_one_read_enable,
    output logic marginal_zero_read_enable,
    output logic irq
);
    localparam int CW = fsr_pkg::TIMER_W;

    logic [7:0] awaddr_q;
    logic aw_have_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_have_q;
    logic wr_go;
    logic key_ok;
    logic full_lanes;
    logic segment_a_lock_q;
    logic emergency_exit_q;
    logic lock_q;
    logic fail_q;
    logic access_violation_flag_q;
    logic key_violation_flag_q;
    logic emergency_exit_on_interrupt_enable_q;
    logic [4:0] op_q;
    logic marginal_one_read_enable_q;
    logic marginal_zero_read_enable_q;
    logic [fsr_pkg::IRQ_W-1:0] irq_stat_q;
    logic [fsr_pkg::IRQ_W-1:0] irq_mask_q;
    logic [fsr_pkg::IRQ_W-1:0] irq_event;
    logic start_req;
    logic start_ok;
    logic start_bad;
    logic abort_op;
    logic tg_busy;
    logic tg_done;
    logic [CW-1:0] tg_cycles;
    logic [7:0] status_byte;
    logic [31:0] rd_word;
    logic rd_hit_irq;

    // write channels may arrive in either order; hold each until both are here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_have_q <= 1'b0;
            end
        end
    end

    assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
    assign full_lanes = (wstrb_q[1:0] == 2'h3);
    assign key_ok = (wdata_q[15:8] == fsr_pkg::KEY_WRITE) && full_lanes;

    // ready signals and write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                case (awaddr_q)
                    fsr_pkg::ADDR_STATUS_LOCK, fsr_pkg::ADDR_MARGINAL,
                    fsr_pkg::ADDR_IRQ_MASK, fsr_pkg::ADDR_OP_CTRL: s_axi_bresp <= 2'h0;
                    default: s_axi_bresp <= 2'h2;
                endcase
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // a write to the status/lock or marginal register with a wrong key asks for power-up clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_up_clear_reset <= 1'b0;
        end else begin
            power_up_clear_reset <= wr_go && !key_ok &&
                (awaddr_q == fsr_pkg::ADDR_STATUS_LOCK || awaddr_q == fsr_pkg::ADDR_MARGINAL);
        end
    end

    // key violation survives the power-up clear; only power-on clears it
    always_ff @(posedge aclk) begin
        if (!por_n) begin
            key_violation_flag_q <= 1'b0;
        end else if (wr_go && !key_ok && (awaddr_q == fsr_pkg::ADDR_STATUS_LOCK ||
                     awaddr_q == fsr_pkg::ADDR_MARGINAL)) begin
            key_violation_flag_q <= 1'b1;
        end
    end

    // writable bits of the status/lock register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            segment_a_lock_q <= fsr_pkg::RST_SEGMENT_A_LOCK;
            emergency_exit_q <= 1'b0;
            lock_q <= fsr_pkg::RST_LOCK;
        end else if (wr_go && key_ok && awaddr_q == fsr_pkg::ADDR_STATUS_LOCK) begin
            // segment lock toggles when written as 1
            if (wdata_q[fsr_pkg::BIT_SEGMENT_A_LOCK]) begin
                segment_a_lock_q <= !segment_a_lock_q;
            end
            emergency_exit_q <= wdata_q[fsr_pkg::BIT_EMERGENCY_EXIT];
            lock_q <= wdata_q[fsr_pkg::BIT_LOCK];
        end
    end

    // operation control: mode bits, exit-on-interrupt, start
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            op_q <= 5'h00;
            emergency_exit_on_interrupt_enable_q <= 1'b0;
        end else if (abort_op) begin
            op_q <= 5'h00;
        end else if (wr_go && key_ok && awaddr_q == fsr_pkg::ADDR_OP_CTRL) begin
            op_q <= wdata_q[4:0];
            emergency_exit_on_interrupt_enable_q <= wdata_q[7];
        end
    end

    assign start_req = wr_go && key_ok && awaddr_q == fsr_pkg::ADDR_OP_CTRL &&
        wdata_q[fsr_pkg::OP_START] && !tg_busy;
    // locked controller, or protected info segment without mass erase, refuses the operation
    assign start_bad = start_req && (lock_q || (wdata_q[fsr_pkg::OP_INFO] &&
        segment_a_lock_q && !wdata_q[fsr_pkg::OP_MASS]));
    assign start_ok = start_req && !start_bad;
    assign tg_cycles = (wdata_q[fsr_pkg::OP_ERASE] || wdata_q[fsr_pkg::OP_MASS]) ?
        CW'(ERASE_CYC) : CW'(WRITE_CYC);
    assign abort_op = tg_busy && (emergency_exit_q ||
        (irq_during_op && emergency_exit_on_interrupt_enable_q));

    // timing generator; lock is not an input, so it never aborts a running operation
    fsr_timing_gen #(.CW(CW)) u_timing (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(start_ok),
        .cycles(tg_cycles),
        .abort(abort_op),
        .busy(tg_busy),
        .done(tg_done)
    );

    // failure and access violation flags; set wins over software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fail_q <= 1'b0;
            access_violation_flag_q <= 1'b0;
        end else begin
            if (abort_op) begin
                fail_q <= 1'b1;
            end else if (wr_go && key_ok && awaddr_q == fsr_pkg::ADDR_STATUS_LOCK) begin
                fail_q <= wdata_q[fsr_pkg::BIT_FAIL];
            end
            if (start_bad) begin
                access_violation_flag_q <= 1'b1;
            end else if (wr_go && key_ok && awaddr_q == fsr_pkg::ADDR_STATUS_LOCK) begin
                access_violation_flag_q <= wdata_q[fsr_pkg::BIT_ACCV];
            end
        end
    end

    // marginal read enables; instruction fetch from flash drops the one-read enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            marginal_one_read_enable_q <= 1'b0;
            marginal_zero_read_enable_q <= 1'b0;
        end else begin
            if (wr_go && key_ok && awaddr_q == fsr_pkg::ADDR_MARGINAL) begin
                marginal_one_read_enable_q <= wdata_q[fsr_pkg::BIT_MARGINAL_ONE_READ_ENABLE];
                marginal_zero_read_enable_q <= wdata_q[fsr_pkg::BIT_MARGINAL_ZERO_READ_ENABLE];
            end
            if (cpu_fetch_from_flash) begin
                marginal_one_read_enable_q <= 1'b0;
            end
        end
    end

    assign marginal_one_read_enable = marginal_one_read_enable_q;
    assign marginal_zero_read_enable = marginal_zero_read_enable_q;

    // live status byte: busy and wait follow the timing generator
    always_comb begin
        status_byte = 8'h00;
        status_byte[fsr_pkg::BIT_FAIL] = fail_q;
        status_byte[fsr_pkg::BIT_SEGMENT_A_LOCK] = segment_a_lock_q;
        status_byte[fsr_pkg::BIT_EMERGENCY_EXIT] = emergency_exit_q;
        status_byte[fsr_pkg::BIT_LOCK] = lock_q;
        status_byte[fsr_pkg::BIT_WAIT] = !tg_busy;
        status_byte[fsr_pkg::BIT_ACCV] = access_violation_flag_q;
        status_byte[fsr_pkg::BIT_KEY_VIOLATION_FLAG] = key_violation_flag_q;
        status_byte[fsr_pkg::BIT_BUSY] = tg_busy;
    end

    // interrupt events and sticky status, cleared by a read; a new event wins
    assign irq_event = {tg_done, start_bad, abort_op, power_up_clear_reset};
    assign rd_hit_irq = s_axi_arvalid && s_axi_arready && s_axi_araddr == fsr_pkg::ADDR_IRQ_STATUS;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            irq <= 1'b0;
        end else begin
            irq_stat_q <= (rd_hit_irq ? '0 : irq_stat_q) | irq_event;
            if (wr_go && awaddr_q == fsr_pkg::ADDR_IRQ_MASK) begin
                irq_mask_q <= wdata_q[fsr_pkg::IRQ_W-1:0];
            end
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // read decode: the status/lock and marginal registers return the read key in bits 15:8
    always_comb begin
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            fsr_pkg::ADDR_STATUS_LOCK: rd_word = {16'h0000, fsr_pkg::KEY_READ, status_byte};
            fsr_pkg::ADDR_MARGINAL: rd_word = {16'h0000, fsr_pkg::KEY_READ, 2'b00, marginal_one_read_enable_q, marginal_zero_read_enable_q,
                4'h0};
            fsr_pkg::ADDR_IRQ_STATUS: rd_word = {28'h0000000, irq_stat_q};
            fsr_pkg::ADDR_IRQ_MASK: rd_word = {28'h0000000, irq_mask_q};
            fsr_pkg::ADDR_OP_CTRL: rd_word = {24'h000000,
                emergency_exit_on_interrupt_enable_q, 1'b0, tg_busy, op_q};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // read channel: one cycle from address taken to data valid
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                case (s_axi_araddr)
                    fsr_pkg::ADDR_STATUS_LOCK, fsr_pkg::ADDR_MARGINAL, fsr_pkg::ADDR_IRQ_STATUS,
                    fsr_pkg::ADDR_IRQ_MASK, fsr_pkg::ADDR_OP_CTRL: s_axi_rresp <= 2'h0;
                    default: s_axi_rresp <= 2'h2;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// ### verif/fsr_top_assertions.sv
// checker for the flash status block's bus, key and marginal read ports
`timescale 1ns/1ps
module fsr_checker #(
    parameter int WRITE_CYC = 8,
    parameter int ERASE_CYC = 20
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic cpu_fetch_from_flash,
    input wire logic power_up_clear_reset,
    input wire logic marginal_one_read_enable,
    input wire logic marginal_zero_read_enable
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic [7:0] rd_addr_q;
    // remember the address of the read under way
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_addr_q <= 8'h00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_q <= s_axi_araddr;
        end
    end
    // address and data taken together
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence key_wr;
        wr_taken ##0 (s_axi_awaddr == 8'h00 || s_axi_awaddr == 8'h04);
    endsequence
    sequence bad_key_wr;
        key_wr ##0 (s_axi_wdata[15:8] != fsr_pkg::KEY_WRITE);
    endsequence
    sequence marg_zero_wr;
        key_wr ##0 (s_axi_awaddr == 8'h04 && s_axi_wdata[15:8] == fsr_pkg::KEY_WRITE &&
            s_axi_wdata[fsr_pkg::BIT_MARGINAL_ZERO_READ_ENABLE] && s_axi_wstrb == 4'hF);
    endsequence
    a_read_key_byte: assert property (s_axi_rvalid && rd_addr_q <= 8'h04 && rd_addr_q[1:0] == 2'b00
        |-> s_axi_rdata[15:8] == fsr_pkg::KEY_READ) else $error("key byte wrong on read");
    a_bad_key_reset: assert property (bad_key_wr |-> ##[1:3] power_up_clear_reset)
        else $error("no reset request after wrong key");
    a_reset_one_pulse: assert property (power_up_clear_reset |=> !power_up_clear_reset)
        else $error("reset request longer than one cycle");
    a_write_resp_time: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response not two cycles late");
    a_read_resp_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_fetch_clears_one: assert property (cpu_fetch_from_flash ##1 cpu_fetch_from_flash
        |-> !marginal_one_read_enable) else $error("marginal one kept during fetch");
    a_unmapped_err: assert property (s_axi_rvalid && rd_addr_q > 8'h10
        |-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");
    a_marg_zero_set: assert property (marg_zero_wr |-> ##[1:3] marginal_zero_read_enable)
        else $error("marginal zero not enabled");
endmodule
bind fsr_top fsr_checker #(.WRITE_CYC(WRITE_CYC), .ERASE_CYC(ERASE_CYC)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .cpu_fetch_from_flash(cpu_fetch_from_flash),
    .power_up_clear_reset(power_up_clear_reset),
    .marginal_one_read_enable(marginal_one_read_enable),
    .marginal_zero_read_enable(marginal_zero_read_enable));

// ### verif/test_fsr_top.sv
// self-checking bench for the flash status and marginal read registers
`timescale 1ns/1ps
module test_fsr_top;
    localparam int WCYC = 8;
    logic aclk, aresetn, por_n, cpu_fetch_from_flash, irq_during_op, irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp_q;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic power_up_clear_reset, marginal_one_read_enable, marginal_zero_read_enable;
    int err_count, tests_run;
    int pulses = 0;
    fsr_top #(.WRITE_CYC(WCYC), .ERASE_CYC(20)) i_fsr_top (
        .aclk(aclk), .aresetn(aresetn), .por_n(por_n), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .cpu_fetch_from_flash(cpu_fetch_from_flash),
        .irq_during_op(irq_during_op), .power_up_clear_reset(power_up_clear_reset),
        .marginal_one_read_enable(marginal_one_read_enable),
        .marginal_zero_read_enable(marginal_zero_read_enable), .irq(irq));
    // free-running bus clock
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // count reset request pulses
    always @(posedge aclk) begin
        if (power_up_clear_reset === 1'b1) begin
            pulses <= pulses + 1;
        end
    end
    // one write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        resp_q = s_axi_bresp;
    endtask
    // one read, data and response taken at the edge rvalid is seen
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        rd_q = s_axi_rdata;
        resp_q = s_axi_rresp;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rd(a);
        chk($sformatf("reg %h", a), e, rd_q & m);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // hang guard, far beyond the expected run
    initial begin
        repeat (4000) @(posedge aclk);
        err_count++;
        finish_test;
    end
    // main sequence
    initial begin
        err_count = 0;
        tests_run = 0;
        {aresetn, por_n, cpu_fetch_from_flash, irq_during_op} = 4'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
        {s_axi_bready, s_axi_rready} = 2'h3;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        repeat (16) @(posedge aclk);
        {aresetn, por_n} <= 2'h3;
        repeat (2) @(posedge aclk);
        rchk(8'h00, 32'hFFFFFFFF, 32'h00009658);
        rchk(8'h04, 32'hFFFFFFFF, 32'h00009600);
        wr(8'h04, 32'h0000A530);
        rchk(8'h04, 32'hFFFFFFFF, 32'h00009630);
        chk("marg", 32'h3, {marginal_one_read_enable, marginal_zero_read_enable});
        cpu_fetch_from_flash <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("marg", 32'h1, {marginal_one_read_enable, marginal_zero_read_enable});
        cpu_fetch_from_flash <= 1'b0;
        rchk(8'h04, 32'hFFFF, 32'h9610);
        // wrong key: request, flag, interrupt
        wr(8'h0C, 32'h0000000F);
        wr(8'h00, 32'h00005A10);
        repeat (2) @(posedge aclk);
        chk("pulses", 32'h1, pulses);
        chk("irq", 32'h1, irq);
        rchk(8'h00, 32'h0002, 32'h0002);
        rchk(8'h08, 32'h0001, 32'h0001);
        rchk(8'h08, 32'h0001, 32'h0000);
        repeat (2) @(posedge aclk);
        chk("irq", 32'h0, irq);
        // a correct-key write of zero must not clear the violation
        wr(8'h00, 32'h0000A510);
        chk("bresp", 32'h0, resp_q);
        rchk(8'h00, 32'h0002, 32'h0002);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rchk(8'h00, 32'h0002, 32'h0002);
        {aresetn, por_n} <= 2'h0;
        repeat (2) @(posedge aclk);
        {aresetn, por_n} <= 2'h3;
        repeat (2) @(posedge aclk);
        rchk(8'h00, 32'hFFFF, 32'h9658);
        // write operation locked midway still completes
        wr(8'h00, 32'h0000A500);
        wr(8'h10, 32'h0000A524);
        rchk(8'h00, 32'h0009, 32'h0001);
        wr(8'h00, 32'h0000A510);
        repeat (WCYC + 4) @(posedge aclk);
        rchk(8'h00, 32'h0081, 32'h0000);
        rchk(8'h08, 32'h0008, 32'h0008);
        // emergency exit stops a running erase
        wr(8'h00, 32'h0000A500);
        wr(8'h10, 32'h0000A521);
        rchk(8'h00, 32'h0001, 32'h0001);
        wr(8'h00, 32'h0000A520);
        rchk(8'h00, 32'h0081, 32'h0080);
        wr(8'h00, 32'h0000A500);
        wr(8'h10, 32'h0000A531);
        rchk(8'h00, 32'h0005, 32'h0004);
        wr(8'h00, 32'h0000A500);
        // interrupt aborts when exit on interrupt is enabled
        wr(8'h10, 32'h0000A5A1);
        irq_during_op <= 1'b1;
        repeat (2) @(posedge aclk);
        irq_during_op <= 1'b0;
        rchk(8'h00, 32'h0081, 32'h0080);
        wr(8'h20, 32'h0000A500);
        chk("bresp", 32'h2, resp_q);
        chk("pulses", 32'h1, pulses);
        rd(8'h20);
        chk("resp", 32'h2, resp_q);
        finish_test;
    end
endmodule
